// ===== common/opdec_params.svh
// named constants for the operand addressing mode decoder
// assumes inclusion by bare name from package and design files
`ifndef OPDEC_PARAMS_SVH
`define OPDEC_PARAMS_SVH
// ------------------------------------------------------------
// field widths
// ------------------------------------------------------------
`define OPD_REG_W     4
`define OPD_LIT_W     16
`define OPD_LIT8_W    8
`define OPD_HOLD_W    14
`define OPD_STEP_W    3
// ------------------------------------------------------------
// prefetch pointer register numbers
// ------------------------------------------------------------
`define OPD_XPTR_A    4'h8
`define OPD_XPTR_B    4'h9
`define OPD_YPTR_A    4'ha
`define OPD_YPTR_B    4'hb
// ------------------------------------------------------------
// post-modify steps in bytes
// ------------------------------------------------------------
`define OPD_STEP_0    3'h0
`define OPD_STEP_2    3'h2
`define OPD_STEP_4    3'h4
`define OPD_STEP_6    3'h6
`endif

// ===== common/opdec_pkg.sv
// types shared by the operand decoder and its bench
// assumes opdec_params.svh is on the include path
package opdec_pkg;
`include "opdec_params.svh"
   // ------------------------------------------------------------
   // instruction classes
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      CLS_NOP    = 3'h0,
      CLS_MOVE   = 3'h1,
      CLS_DSP    = 3'h2,
      CLS_BRANCH = 3'h3,
      CLS_HOLD   = 3'h4,
      CLS_UNLINK = 3'h5,
      CLS_INT    = 3'h6
   } op_class_type;
   // general addressing modes
   typedef enum logic [2:0] {
      AM_DIRECT  = 3'h0,
      AM_IND     = 3'h1,
      AM_POST    = 3'h2,
      AM_PRE     = 3'h3,
      AM_INDEXED = 3'h4,
      AM_LITOFS  = 3'h5,
      AM_LIT8    = 3'h6,
      AM_LIT16   = 3'h7
   } addr_mode_type;
   // dual-source pointer modes
   typedef enum logic [2:0] {
      DM_IND     = 3'h0,
      DM_PM2     = 3'h1,
      DM_PM4     = 3'h2,
      DM_PM6     = 3'h3,
      DM_INDEXED = 3'h4
   } dsp_mode_type;
   // ------------------------------------------------------------
   // request from fetch, result to execute
   // ------------------------------------------------------------
   typedef struct packed {
      logic                   valid;
      op_class_type           opClass;
      addr_mode_type          srcMode;
      addr_mode_type          dstMode;
      logic [`OPD_REG_W-1:0]  srcReg;
      logic [`OPD_REG_W-1:0]  dstReg;
      logic [`OPD_REG_W-1:0]  offsetReg;
      logic [`OPD_REG_W-1:0]  xReg;
      dsp_mode_type           xMode;
      logic [`OPD_REG_W-1:0]  yReg;
      dsp_mode_type           yMode;
      logic [`OPD_LIT_W-1:0]  literal;
   } dec_req_type;
   typedef struct packed {
      logic                   valid;
      logic                   illegal;
      op_class_type           opClass;
      addr_mode_type          srcMode;
      addr_mode_type          dstMode;
      logic [`OPD_REG_W-1:0]  srcReg;
      logic [`OPD_REG_W-1:0]  dstReg;
      logic [`OPD_REG_W-1:0]  offsetReg;
      logic                   offsetUsed;
      logic                   xAguEn;
      logic [`OPD_REG_W-1:0]  xAguReg;
      logic [`OPD_STEP_W-1:0] xStep;
      logic                   xIndexed;
      logic                   yAguEn;
      logic [`OPD_REG_W-1:0]  yAguReg;
      logic [`OPD_STEP_W-1:0] yStep;
      logic                   yIndexed;
      logic                   immValid;
      logic                   immSigned;
      logic [`OPD_LIT_W-1:0]  immValue;
      logic                   implied;
      logic                   operandActive;
   } dec_res_type;
endpackage : opdec_pkg

// ===== verilog/operand_address_mode_decode.sv
// operand addressing mode decode and check, one stage
// assumes fetch presents decoded fields on clk, same domain
// assumes ce low holds every output through a pipeline stall
// assumes execute traps any result flagged illegal
//
// Function
// - move source and destination modes are chosen independently
// - one 4-bit offset register field serves both move sides
// - move class supports indexed mode beside the common integer modes
// - move class supports literal offset and 8/16-bit literal operands
// - dual-source pointers limited to the two X and two Y pointers
// - X pointers go to X address generator, Y pointers to Y
// - dual-source indexed mode only on second X and second Y pointer
// - dual-source supports indirect and post-modify by 2, 4 or 6
// - branch target comes from a signed 16-bit literal
// - interrupt hold decodes an unsigned 14-bit literal
// - frame unlink operands are implied by the opcode
// - no-operation has no operands and no address activity
`timescale 1ns/1ps
`include "opdec_params.svh"
module operand_address_mode_decode #(
   parameter int OFFSET_BITS = 4
) (
   input  wire logic                  clk,
   input  wire logic                  sys_rst,
   input  wire logic                  ce,
   input  wire opdec_pkg::dec_req_type req,
   output      opdec_pkg::dec_res_type res
);
   import opdec_pkg::*;

   // ------------------------------------------------------------
   // elaboration check
   // ------------------------------------------------------------
   // the struct carries a fixed field, so other widths cannot work
   if (OFFSET_BITS != `OPD_REG_W) begin : g_bad_width
      $error("OFFSET_BITS must equal the register field width");
   end

   // ------------------------------------------------------------
   // class decode
   // ------------------------------------------------------------
   wire logic isMove   = req.opClass == CLS_MOVE;
   wire logic isDsp    = req.opClass == CLS_DSP;
   wire logic isBranch = req.opClass == CLS_BRANCH;
   wire logic isHold   = req.opClass == CLS_HOLD;
   wire logic isUnlink = req.opClass == CLS_UNLINK;
   wire logic isInt    = req.opClass == CLS_INT;
   wire logic isNop    = req.opClass == CLS_NOP;
   wire logic classOk  = isMove | isDsp | isBranch | isHold
                       | isUnlink | isInt | isNop;

   // ------------------------------------------------------------
   // general operand mode checks
   // ------------------------------------------------------------
   // common integer modes stop at pre-modify
   wire logic srcCommon = req.srcMode <= AM_PRE;
   wire logic dstCommon = req.dstMode <= AM_PRE;
   // limitation: every source code is a mode, so nothing is refused here
   // move source takes any mode; each side checked on its own
   wire logic moveSrcOk = 1'b1;
   // a literal cannot be written, so it is refused as destination
   wire logic moveDstOk = req.dstMode != AM_LIT8
                        && req.dstMode != AM_LIT16;
   wire logic moveOk    = moveSrcOk & moveDstOk;
   wire logic intOk     = srcCommon & dstCommon;
   // shared offset field, normally used by one side only
   wire logic offsetUse = isMove & (req.srcMode == AM_INDEXED
                        | req.dstMode == AM_INDEXED);

   // ------------------------------------------------------------
   // dual-source pointer checks
   // ------------------------------------------------------------
   wire logic xRegOk = req.xReg == `OPD_XPTR_A
                     | req.xReg == `OPD_XPTR_B;
   wire logic yRegOk = req.yReg == `OPD_YPTR_A
                     | req.yReg == `OPD_YPTR_B;
   wire logic xIdx   = req.xMode == DM_INDEXED;
   wire logic yIdx   = req.yMode == DM_INDEXED;
   // indexed only on the second pointer of each side
   wire logic xModeOk = req.xMode <= DM_PM6
                      | (xIdx & req.xReg == `OPD_XPTR_B);
   wire logic yModeOk = req.yMode <= DM_PM6
                      | (yIdx & req.yReg == `OPD_YPTR_B);
   wire logic dspOk   = xRegOk & yRegOk & xModeOk & yModeOk;

   // ------------------------------------------------------------
   // legality and step selection
   // ------------------------------------------------------------
   wire logic legal = classOk & (isMove ? moveOk
                    : isDsp ? dspOk
                    : isInt ? intOk : 1'b1);

   // post-modify step in bytes per pointer mode
   function automatic logic [`OPD_STEP_W-1:0] stepOf(input dsp_mode_type m);
      logic [`OPD_STEP_W-1:0] s;
      s = `OPD_STEP_0;
      case (m)
         DM_PM2:  s = `OPD_STEP_2;
         DM_PM4:  s = `OPD_STEP_4;
         DM_PM6:  s = `OPD_STEP_6;
         default: s = `OPD_STEP_0;
      endcase
      return s;
   endfunction : stepOf

   wire logic dspGo = isDsp & legal;
   // X pointers only ever reach the X generator, Y only the Y one
   wire logic [`OPD_REG_W-1:0]  xRoute = dspGo ? req.xReg : '0;
   wire logic [`OPD_REG_W-1:0]  yRoute = dspGo ? req.yReg : '0;
   wire logic [`OPD_STEP_W-1:0] xStepV = dspGo ? stepOf(req.xMode) : `OPD_STEP_0;
   wire logic [`OPD_STEP_W-1:0] yStepV = dspGo ? stepOf(req.yMode) : `OPD_STEP_0;

   // ------------------------------------------------------------
   // immediate field
   // ------------------------------------------------------------
   wire logic moveLit8  = isMove & req.srcMode == AM_LIT8;
   wire logic moveLit16 = isMove & req.srcMode == AM_LIT16;
   wire logic [`OPD_LIT_W-1:0] lit8Ext =
      {{(`OPD_LIT_W-`OPD_LIT8_W){1'b0}}, req.literal[`OPD_LIT8_W-1:0]};
   wire logic [`OPD_LIT_W-1:0] holdExt =
      {{(`OPD_LIT_W-`OPD_HOLD_W){1'b0}}, req.literal[`OPD_HOLD_W-1:0]};
   wire logic immV = legal & (isBranch | isHold | moveLit8 | moveLit16);
   wire logic [`OPD_LIT_W-1:0] immSel =
      isBranch  ? req.literal
    : isHold    ? holdExt
    : moveLit8  ? lit8Ext
    : moveLit16 ? req.literal : '0;

   // ------------------------------------------------------------
   // assembled next result
   // ------------------------------------------------------------
   // nop and unlink carry no explicit operand fields
   wire logic explicitOps = legal & (isMove | isInt);
   dec_res_type next_res;
   always_comb begin
      next_res               = '0;
      next_res.valid         = req.valid;
      next_res.illegal       = req.valid & ~legal;
      next_res.opClass       = req.opClass;
      next_res.srcMode       = explicitOps ? req.srcMode : AM_DIRECT;
      next_res.dstMode       = explicitOps ? req.dstMode : AM_DIRECT;
      next_res.srcReg        = explicitOps ? req.srcReg : '0;
      next_res.dstReg        = explicitOps ? req.dstReg : '0;
      next_res.offsetReg     = offsetUse & legal ? req.offsetReg : '0;
      next_res.offsetUsed    = offsetUse & legal;
      next_res.xAguEn        = dspGo;
      next_res.xAguReg       = xRoute;
      next_res.xStep         = xStepV;
      next_res.xIndexed      = dspGo & xIdx;
      next_res.yAguEn        = dspGo;
      next_res.yAguReg       = yRoute;
      next_res.yStep         = yStepV;
      next_res.yIndexed      = dspGo & yIdx;
      next_res.immValid      = immV;
      next_res.immSigned     = isBranch;
      next_res.immValue      = immV ? immSel : '0;
      next_res.implied       = isUnlink;
      next_res.operandActive = legal & ~isNop & ~isBranch & ~isHold;
   end

   // ------------------------------------------------------------
   // output register
   // ------------------------------------------------------------
   // one stage keeps outputs glitch free for the execute stage
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         res <= '0;
      end else if (ce) begin
         res <= next_res;
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   wire logic step = ce & req.valid;

   move_modes_a: assert property (step & isMove & moveOk |=>
      res.srcMode == $past(req.srcMode) && res.dstMode == $past(req.dstMode))
      else $error("move modes not passed independently");
   offset_shared_a: assert property (step & isMove & req.dstMode == AM_INDEXED |=>
      res.offsetUsed && res.offsetReg == $past(req.offsetReg))
      else $error("shared offset field not used");
   move_indexed_a: assert property (step & isMove & req.srcMode == AM_INDEXED
      |=> !res.illegal)
      else $error("move indexed refused");
   move_lit8_a: assert property (step & isMove & moveOk & req.srcMode == AM_LIT8
      |=> res.immValid && res.immValue == {8'h00, $past(req.literal[7:0])})
      else $error("8-bit literal wrong");
   dsp_ptrset_a: assert property (step & isDsp & (req.xReg < `OPD_XPTR_A)
      |=> res.illegal && !res.xAguEn)
      else $error("bad dual-source pointer accepted");
   dsp_route_a: assert property (res.xAguEn |->
      (res.xAguReg == `OPD_XPTR_A || res.xAguReg == `OPD_XPTR_B)
      && (res.yAguReg == `OPD_YPTR_A || res.yAguReg == `OPD_YPTR_B))
      else $error("pointer routed to wrong generator");
   dsp_index_a: assert property (step & isDsp & xIdx
      & req.xReg == `OPD_XPTR_A |=> res.illegal)
      else $error("indexed on first X pointer accepted");
   dsp_step_a: assert property (step & dspGo & req.yMode == DM_PM6
      |=> res.yStep == `OPD_STEP_6)
      else $error("post-modify step wrong");
   branch_lit_a: assert property (step & isBranch |=>
      res.immSigned && res.immValue == $past(req.literal))
      else $error("branch literal wrong");
   hold_lit_a: assert property (step & isHold |=>
      !res.immSigned && res.immValue[15:14] == 2'h0
      && res.immValue[13:0] == $past(req.literal[13:0]))
      else $error("hold literal wrong");
   unlink_impl_a: assert property (step & isUnlink |=>
      res.implied && res.srcReg == '0 && !res.xAguEn)
      else $error("unlink not implied");
   nop_quiet_a: assert property (step & isNop |=>
      !res.operandActive && !res.xAguEn && !res.immValid && !res.offsetUsed)
      else $error("nop shows operand activity");
   ce_freeze_a: assert property (!ce |=> $stable(res))
      else $error("output moved with clock enable low");

   // move class: literals, literal offset and the shared offset field
   move_lit16_a: assert property (step & isMove & moveOk & req.srcMode == AM_LIT16
      |=> res.immValid && res.immValue == $past(req.literal))
      else $error("16-bit literal wrong");
   move_litofs_a: assert property (step & isMove & moveOk & req.srcMode == AM_LITOFS
      |=> !res.illegal && res.srcMode == AM_LITOFS && !res.immValid)
      else $error("literal offset mode refused");
   move_noimm_a: assert property (step & isMove & req.srcMode <= AM_LITOFS
      |=> !res.immValid)
      else $error("immediate shown for a register mode");
   move_dstlit_a: assert property (step & isMove & req.dstMode >= AM_LIT8
      |=> res.illegal && !res.immValid && !res.offsetUsed)
      else $error("literal destination accepted");
   offset_src_a: assert property (step & isMove & moveOk & req.srcMode == AM_INDEXED
      |=> res.offsetUsed && res.offsetReg == $past(req.offsetReg))
      else $error("source side offset not used");

   // integer class: common modes only, no offset field
   int_modes_a: assert property (step & isInt & (req.srcMode > AM_PRE | req.dstMode > AM_PRE)
      |=> res.illegal && res.srcReg == '0)
      else $error("integer class took an extended mode");
   int_pass_a: assert property (step & isInt & srcCommon & dstCommon |=> !res.illegal
      && res.srcReg == $past(req.srcReg) && res.dstReg == $past(req.dstReg))
      else $error("integer operands not passed");
   int_nooffset_a: assert property (step & isInt |=> !res.offsetUsed)
      else $error("offset field used outside move class");

   // dual-source: pointer set, indexed placement, steps and routing
   x_range_a: assert property (step & isDsp & req.xReg > `OPD_XPTR_B
      |=> res.illegal && !res.xAguEn)
      else $error("X pointer above the set accepted");
   y_ptrset_a: assert property (step & isDsp & (req.yReg < `OPD_YPTR_A | req.yReg > `OPD_YPTR_B)
      |=> res.illegal && !res.yAguEn)
      else $error("bad Y pointer accepted");
   y_index_a: assert property (step & isDsp & yIdx & req.yReg == `OPD_YPTR_A
      |=> res.illegal)
      else $error("indexed on first Y pointer accepted");
   dsp_noidx_a: assert property (step & dspGo & !xIdx |=> !res.xIndexed)
      else $error("indexed flag without indexed mode");
   x_step_a: assert property (step & dspGo & req.xMode == DM_PM2
      |=> res.xStep == `OPD_STEP_2)
      else $error("X post-modify step wrong");
   y_step4_a: assert property (step & dspGo & req.yMode == DM_PM4
      |=> res.yStep == `OPD_STEP_4)
      else $error("Y post-modify step wrong");
   dsp_badmode_a: assert property (step & isDsp & (req.xMode > DM_INDEXED | req.yMode > DM_INDEXED)
      |=> res.illegal && !res.xAguEn)
      else $error("reserved pointer mode accepted");
   route_pass_a: assert property (step & dspGo |=> res.xAguReg == $past(req.xReg)
      && res.yAguReg == $past(req.yReg))
      else $error("pointer not passed to its generator");
   dsp_only_a: assert property (step & ~isDsp |=> !res.xAguEn && !res.yAguEn
      && res.xStep == `OPD_STEP_0)
      else $error("address generator busy outside dual-source");
   dsp_noimm_a: assert property (step & isDsp |=> !res.immValid && !res.offsetUsed)
      else $error("dual-source shows move operand fields");

   // literal sign, implied operands, reserved class, idle slots
   signed_only_a: assert property (step & ~isBranch |=> !res.immSigned)
      else $error("signed literal outside branch");
   branch_noagu_a: assert property (step & isBranch
      |=> res.immValid && !res.xAguEn && !res.operandActive)
      else $error("branch shows operand address activity");
   implied_only_a: assert property (step & ~isUnlink |=> !res.implied)
      else $error("implied operand flag outside unlink");
   unlink_noimm_a: assert property (step & isUnlink
      |=> res.operandActive && !res.immValid && !res.offsetUsed)
      else $error("unlink shows explicit operand fields");
   nop_noreg_a: assert property (step & isNop
      |=> res.srcReg == '0 && res.dstReg == '0 && !res.illegal)
      else $error("nop shows operand registers");
   class_check_a: assert property (step & ~classOk |=> res.illegal && !res.operandActive)
      else $error("reserved class accepted");
   idle_clear_a: assert property (ce & ~req.valid |=> !res.valid && !res.illegal)
      else $error("idle slot flagged");

   move_idx_c: cover property (step & isMove & offsetUse & legal);
   dsp_dual_c: cover property (step & dspGo & xIdx & yIdx);
   illegal_c:  cover property (step & ~legal);
   branch_c:   cover property (step & isBranch ##1 step & isHold);
   int_c:      cover property (step & isInt & intOk);

endmodule : operand_address_mode_decode

// ===== verif/fetch_model.sv
// fetch pipeline model: presents decode requests and collects answers
// assumes the decoder answers one ce edge later on the same clk
`timescale 1ns/1ps
module fetch_model (
   input  wire logic                   clk,
   output      opdec_pkg::dec_req_type req,
   output      logic                   ce,
   input  wire opdec_pkg::dec_res_type res
);
   import opdec_pkg::*;
   // ------------------------------------------------------------
   // request driving
   // ------------------------------------------------------------
   // idle until the bench asks, nothing valid before reset ends
   initial begin
      req = '0;
      ce  = 1'b0;
   end
   // drive after an edge, hold through the answering edge, then read
   task automatic issue(input dec_req_type r, output dec_res_type got);
      @(posedge clk);
      req <= r;      // (pointer numbers are sent as given, out-of-set ones included)
      ce  <= 1'b1;
      @(posedge clk);
      #1 got = res;
   endtask : issue
   // pipeline stall: ce low while fetch drives an all-zero request, answer must freeze
   task automatic stall(input int n, output dec_res_type got);
      @(posedge clk);
      ce  <= 1'b0;
      req <= '0;
      repeat (n) @(posedge clk);
      #1 got = res;
   endtask : stall
endmodule : fetch_model

// ===== verif/testbench.sv
// self-checking bench for the operand addressing mode decoder
// assumes opdec_pkg compiled first, fetch_model drives req and ce
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin nCompared++; if ((gt) !== (ex)) begin errors++; \
   $display("Error %s expected %h seen %h", nm, ex, gt); end end
module testbench;
   import opdec_pkg::*;
   logic        clk;
   logic        sys_rst;
   logic        ce;
   dec_req_type req;
   dec_res_type res;
   int          errors = 0;
   int          nCompared = 0;
   // ------------------------------------------------------------
   // clock, design, far side
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   operand_address_mode_decode #(.OFFSET_BITS(4)) dut_u (.clk(clk), .sys_rst(sys_rst), .ce(ce), .req(req), .res(res));
   fetch_model fetchU (.clk(clk), .req(req), .ce(ce), .res(res));
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [2:0] stepOf(input int md);
      return (md >= 1 && md <= 3) ? 3'(md * 2) : 3'h0;
   endfunction : stepOf
   // a pointer is legal on its own side; indexed only on the second one
   function automatic bit sideOk(input int rg, input int md, input int base);
      return (rg == base || rg == base + 1) && md <= 4 && !(md == 4 && rg == base);
   endfunction : sideOk
   task automatic conclude();
      $display("compared %0d mismatches %0d", nCompared, errors);
      if (errors == 0 && nCompared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : conclude
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   // every source mode against indexed destination, then indirect source against every destination mode
   task automatic move_scenario();
      dec_req_type r;
      dec_res_type g;
      for (int i = 0; i < 8; i++) begin
         r = '0;
         r.valid = 1'b1;
         r.opClass = CLS_MOVE;
         r.srcMode = addr_mode_type'(i);
         r.dstMode = AM_INDEXED;
         r.offsetReg = 4'hc;
         r.srcReg = 4'h6;
         r.literal = 16'hbe7a;
         fetchU.issue(r, g);
         `CHK("moveSrc", addr_mode_type'(i), g.srcMode)
         `CHK("moveSrcReg", 4'h6, g.srcReg)
         `CHK("moveDst", AM_INDEXED, g.dstMode)
         `CHK("offsetUsed", 1'b1, g.offsetUsed)
         `CHK("offsetReg", 4'hc, g.offsetReg)
         `CHK("immValid", 1'(i > 5), g.immValid)
         if (i > 5) `CHK("immValue", (i == 6) ? 16'h007a : 16'hbe7a, g.immValue)
         r.srcMode = AM_IND;
         r.dstMode = addr_mode_type'(i);
         fetchU.issue(r, g);
         `CHK("moveIllegal", 1'(i > 5), g.illegal)
         `CHK("moveDst2", (i > 5) ? AM_DIRECT : addr_mode_type'(i), g.dstMode)
         `CHK("offsetOneSide", 1'(i == 4), g.offsetUsed)
      end
   endtask : move_scenario
   // integer class: common modes pass with their registers, the rest refused
   task automatic int_scenario();
      dec_req_type r;
      dec_res_type g;
      for (int i = 0; i < 8; i++) begin
         r = '0;
         r.valid = 1'b1;
         r.opClass = CLS_INT;
         r.srcMode = addr_mode_type'(i);
         r.dstMode = AM_PRE;
         r.srcReg = 4'h3;
         r.dstReg = 4'h5;
         fetchU.issue(r, g);
         `CHK("intIllegal", 1'(i > 3), g.illegal)
         `CHK("intSrcReg", (i > 3) ? 4'h0 : 4'h3, g.srcReg)
         `CHK("intActive", 1'(i < 4), g.operandActive)
         r.srcMode = AM_DIRECT;
         r.dstMode = addr_mode_type'(i);
         fetchU.issue(r, g);
         `CHK("intDstReg", (i > 3) ? 4'h0 : 4'h5, g.dstReg)
         `CHK("intOffset", 1'b0, g.offsetUsed)
      end
   endtask : int_scenario
   // one dual-source request, expectations from the pointer table
   task automatic dsp_one(input int xr, input int xm, input int yr, input int ym);
      dec_req_type r;
      dec_res_type g;
      bit          ok;
      ok = sideOk(xr, xm, 8) && sideOk(yr, ym, 10);
      r = '0;
      r.valid = 1'b1;
      r.opClass = CLS_DSP;
      r.xReg = 4'(xr);
      r.xMode = dsp_mode_type'(xm);
      r.yReg = 4'(yr);
      r.yMode = dsp_mode_type'(ym);
      fetchU.issue(r, g);
      `CHK("dspIllegal", 1'(!ok), g.illegal)
      `CHK("dspValid", 1'b1, g.valid)
      `CHK("xAguEn", 1'(ok), g.xAguEn)
      `CHK("yAguEn", 1'(ok), g.yAguEn)
      `CHK("xAguReg", ok ? 4'(xr) : 4'h0, g.xAguReg)
      `CHK("yAguReg", ok ? 4'(yr) : 4'h0, g.yAguReg)
      if (ok) begin
         `CHK("xStep", stepOf(xm), g.xStep)
         `CHK("yStep", stepOf(ym), g.yStep)
         `CHK("xIndexed", 1'(xm == 4), g.xIndexed)
         `CHK("yIndexed", 1'(ym == 4), g.yIndexed)
      end
   endtask : dsp_one
   // all four pointers and all eight mode codes on each side
   task automatic dsp_scenario();
      for (int rg = 7; rg < 12; rg++) begin
         for (int md = 0; md < 8; md++) begin
            dsp_one(rg, md, 11, 3);
            dsp_one(9, 1, rg + 1, md);
         end
      end
   endtask : dsp_scenario
   // literal classes, implied operands, no-operation, reserved class
   task automatic other_scenario();
      dec_req_type r;
      dec_res_type g;
      r = '0;
      r.valid = 1'b1;
      r.opClass = CLS_BRANCH;
      r.literal = 16'h8001;
      fetchU.issue(r, g);
      `CHK("braSigned", 1'b1, g.immSigned)
      `CHK("braValue", 16'h8001, g.immValue)
      r.opClass = CLS_HOLD;
      r.literal = 16'hffff;
      fetchU.issue(r, g);
      `CHK("holdSigned", 1'b0, g.immSigned)
      `CHK("holdValue", 16'h3fff, g.immValue)
      r.opClass = CLS_UNLINK;
      fetchU.issue(r, g);
      `CHK("unlinkImplied", 1'b1, g.implied)
      `CHK("unlinkActive", 1'b1, g.operandActive)
      dsp_one(9, 4, 11, 4);
      r.opClass = CLS_NOP;
      fetchU.issue(r, g);
      `CHK("nopActive", 1'b0, g.operandActive)
      `CHK("nopAgu", 2'b00, {g.xAguEn, g.yAguEn})
      `CHK("nopImm", 2'b00, {g.immValid, g.offsetUsed})
      r.opClass = op_class_type'(3'h7);
      fetchU.issue(r, g);
      `CHK("reservedClass", 1'b1, g.illegal)
      `CHK("reservedCode", 3'h7, g.opClass)
      r.valid = 1'b0;
      fetchU.issue(r, g);
      `CHK("idleFlags", 2'b00, {g.valid, g.illegal})
   endtask : other_scenario
   // stall freezes a dual-source answer, then reset clears it mid-run
   task automatic stall_reset_scenario();
      dec_res_type g;
      dsp_one(8, 2, 10, 1);
      fetchU.stall(3, g);
      `CHK("stallAgu", 1'b1, g.xAguEn)
      `CHK("stallStep", 3'h4, g.xStep)
      @(posedge clk);
      sys_rst <= 1'b1;
      #1;
      `CHK("resetRes", dec_res_type'('0), res)
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
   endtask : stall_reset_scenario
   // ------------------------------------------------------------
   // main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      sys_rst = 1'b1;
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      #1;
      `CHK("afterReset", dec_res_type'('0), res)
      move_scenario();
      int_scenario();
      dsp_scenario();
      other_scenario();
      stall_reset_scenario();
      dsp_one(9, 4, 11, 2);
      conclude();
   end
   // a hung run counts as a mismatch
   initial begin
      repeat (5000) @(posedge clk);
      errors++;
      conclude();
   end
endmodule : testbench
